// ---- tvr_defines.vh ----
// tvr_defines.vh: command codes, field widths, channel count and reset value of the temperature value registers
// assumes inclusion by the readout modules only
`ifndef TVR_DEFINES_VH
`define TVR_DEFINES_VH

// ****************************************************************
// command codes
// ****************************************************************
`define TVR_CMD_LOCAL_HI   8'h10
`define TVR_CMD_R1S_HI     8'h11
`define TVR_CMD_R2S_HI     8'h12
`define TVR_CMD_R1U_HI     8'h19
`define TVR_CMD_R2U_HI     8'h1a
`define TVR_CMD_LOCAL_LO   8'h20
`define TVR_CMD_R1S_LO     8'h21
`define TVR_CMD_R2S_LO     8'h22
`define TVR_CMD_R1U_LO     8'h29
`define TVR_CMD_R2U_LO     8'h2a

// ****************************************************************
// field layout
// ****************************************************************
`define TVR_LOCAL_FRAC_W   3
`define TVR_REMOTE_FRAC_W  5
`define TVR_FILT_FRAC_W    2
`define TVR_BYTE_RST       8'h00
`define TVR_NUM_CH         5

`endif

// ---- tvr_lsb_hold.v ----
// tvr_lsb_hold.v: one low-byte hold for one temperature reading
// assumes read strobes are one-cycle pulses synchronous to clk_sys
`timescale 1ns/1ps
`include "tvr_defines.vh"

module tvr_lsb_hold (
    clk_sys,
    rst,
    live_lo,
    hi_rd,
    lo_rd,
    lo_out
);
    input  wire       clk_sys;
    input  wire       rst;
    input  wire [7:0] live_lo;
    input  wire       hi_rd;
    input  wire       lo_rd;
    output wire [7:0] lo_out;

    reg        held_r;
    reg  [7:0] cap_r;

    // ****************************************************************
    // capture and release
    // ****************************************************************
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            held_r <= 1'b0;
            cap_r  <= `TVR_BYTE_RST;
        end else if (hi_rd) begin
            held_r <= 1'b1;   // RULE_02
            cap_r  <= live_lo; // RULE_04
        end else if (lo_rd) begin
            held_r <= 1'b0;   // RULE_03
        end
    end

    assign lo_out = held_r ? cap_r : live_lo; // RULE_03
endmodule // tvr_lsb_hold

// ---- tvr_readout.v ----
// tvr_readout.v: read-only temperature value register set with coherent low-byte holds
// assumes the serial engine gives a command code and a one-cycle read strobe
`timescale 1ns/1ps
`include "tvr_defines.vh"

// Overview of operation
// RULE_01: host should read the high byte before the low byte of a reading.
// RULE_02: reading a high byte captures and holds that reading's low byte.
// RULE_03: reading a held low byte returns the capture, then releases the hold.
// RULE_04: each repeated high-byte read recaptures the low byte, replacing the old one.
// RULE_05: local high byte is two's complement integer degrees, +127 to -128.
// RULE_06: local low byte holds half, quarter, eighth; bits 4 to 0 read zero.
// RULE_07: remote low bit 4 is sixteenth degree with filter on, else zero.
// RULE_08: remote low bit 3 is thirty-second degree with filter on, else zero.
// RULE_09: remote low bits 2 to 0 always read zero.
// RULE_10: unsigned remote high byte gives bit 7 weight 128, range 0 to 255.
// RULE_11: signed remote high bytes are at codes 0x11 and 0x12.
// RULE_12: unsigned remote high bytes at 0x19, 0x1a, low bytes at 0x29, 0x2a.
// RULE_13: signed remote low bytes at 0x21, 0x22 regardless of filter setting.
// RULE_14: host selects the register by the command byte of a write.
// RULE_15: each reading has its own independent low-byte hold.
module tvr_readout (
    clk_sys,
    rst,
    local_temp,
    r1_signed_temp,
    r2_signed_temp,
    r1_unsigned_temp,
    r2_unsigned_temp,
    r1_filt_en,
    r2_filt_en,
    cmd_code,
    rd_stb,
    rd_data,
    rd_hit
);
    input  wire        clk_sys;
    input  wire        rst;
    input  wire [10:0] local_temp;
    input  wire [12:0] r1_signed_temp;
    input  wire [12:0] r2_signed_temp;
    input  wire [12:0] r1_unsigned_temp;
    input  wire [12:0] r2_unsigned_temp;
    input  wire        r1_filt_en;
    input  wire        r2_filt_en;
    input  wire [7:0]  cmd_code;
    input  wire        rd_stb;
    output reg  [7:0]  rd_data;
    output reg         rd_hit;

    localparam CH_LOCAL = 0;
    localparam CH_R1S   = 1;
    localparam CH_R2S   = 2;
    localparam CH_R1U   = 3;
    localparam CH_R2U   = 4;

    wire [7:0]             live_hi [0:`TVR_NUM_CH-1];
    wire [7:0]             live_lo [0:`TVR_NUM_CH-1];
    wire [7:0]             held_lo [0:`TVR_NUM_CH-1];
    wire [`TVR_NUM_CH-1:0] hi_rd;
    wire [`TVR_NUM_CH-1:0] lo_rd;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function [7:0] remote_lo;
        input [4:0] frac;
        input       filt;
        begin
            remote_lo = {frac[4:2], frac[1:0] & {2{filt}}, 3'h0}; // RULE_09
        end
    endfunction

    function [4:0] hi_code_hit;
        input [7:0] code;
        begin
            hi_code_hit = {code == `TVR_CMD_R2U_HI, code == `TVR_CMD_R1U_HI, // RULE_12
                           code == `TVR_CMD_R2S_HI, code == `TVR_CMD_R1S_HI, // RULE_11
                           code == `TVR_CMD_LOCAL_HI};
        end
    endfunction

    function [4:0] lo_code_hit;
        input [7:0] code;
        begin
            lo_code_hit = {code == `TVR_CMD_R2U_LO, code == `TVR_CMD_R1U_LO, // RULE_12
                           code == `TVR_CMD_R2S_LO, code == `TVR_CMD_R1S_LO, // RULE_13
                           code == `TVR_CMD_LOCAL_LO};
        end
    endfunction

    // ****************************************************************
    // live byte formatting
    // ****************************************************************
    assign live_hi[CH_LOCAL] = local_temp[10:3];                     // RULE_05
    assign live_lo[CH_LOCAL] = {local_temp[2:0], 5'h00};             // RULE_06
    assign live_hi[CH_R1S]   = r1_signed_temp[12:5];                 // RULE_11
    assign live_lo[CH_R1S]   = remote_lo(r1_signed_temp[4:0], r1_filt_en);   // RULE_07 RULE_08
    assign live_hi[CH_R2S]   = r2_signed_temp[12:5];                 // RULE_11
    assign live_lo[CH_R2S]   = remote_lo(r2_signed_temp[4:0], r2_filt_en);   // RULE_07 RULE_08
    assign live_hi[CH_R1U]   = r1_unsigned_temp[12:5];               // RULE_10
    assign live_lo[CH_R1U]   = remote_lo(r1_unsigned_temp[4:0], r1_filt_en); // RULE_07 RULE_08
    assign live_hi[CH_R2U]   = r2_unsigned_temp[12:5];               // RULE_10
    assign live_lo[CH_R2U]   = remote_lo(r2_unsigned_temp[4:0], r2_filt_en); // RULE_07 RULE_08

    assign hi_rd = hi_code_hit(cmd_code) & {`TVR_NUM_CH{rd_stb}};
    assign lo_rd = lo_code_hit(cmd_code) & {`TVR_NUM_CH{rd_stb}};

    // ****************************************************************
    // per-reading holds
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < `TVR_NUM_CH; gi = gi + 1) begin : g_hold
            tvr_lsb_hold u_hold ( // RULE_15
                .clk_sys (clk_sys),
                .rst     (rst),
                .live_lo (live_lo[gi]),
                .hi_rd   (hi_rd[gi]),
                .lo_rd   (lo_rd[gi]),
                .lo_out  (held_lo[gi])
            );
        end
    endgenerate

    // ****************************************************************
    // read data register
    // ****************************************************************
    reg [7:0] rd_data_nxt;
    reg       rd_hit_nxt;
    integer   ci;

    always @* begin
        rd_data_nxt = `TVR_BYTE_RST;
        rd_hit_nxt  = 1'b0;
        for (ci = 0; ci < `TVR_NUM_CH; ci = ci + 1) begin
            if (hi_rd[ci]) begin
                rd_data_nxt = live_hi[ci];
                rd_hit_nxt  = 1'b1;
            end
            if (lo_rd[ci]) begin
                rd_data_nxt = held_lo[ci]; // RULE_03
                rd_hit_nxt  = 1'b1;
            end
        end
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_data <= `TVR_BYTE_RST;
            rd_hit  <= 1'b0;
        end else if (rd_stb) begin
            rd_data <= rd_data_nxt;
            rd_hit  <= rd_hit_nxt;
        end
    end
endmodule // tvr_readout

// ---- tvr_chk.sv ----
// tvr_chk.sv: port assertions for the readout block
// assumes binding to tvr_readout, one clock, async active-high reset
`timescale 1ns/1ps
module tvr_chk (
    input wire clk_sys,
    input wire rst,
    input wire [10:0] local_temp,
    input wire [12:0] r1_signed_temp,
    input wire [12:0] r2_signed_temp,
    input wire [12:0] r1_unsigned_temp,
    input wire [12:0] r2_unsigned_temp,
    input wire r1_filt_en,
    input wire r2_filt_en,
    input wire [7:0] cmd_code,
    input wire rd_stb,
    input wire [7:0] rd_data,
    input wire rd_hit
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_hi; rd_stb && cmd_code == 8'h11; endsequence
    sequence s_lo; rd_stb && cmd_code == 8'h21; endsequence
    property p_pair; s_hi ##1 !rd_stb [*2] ##1 s_lo |=> rd_data == {$past(r1_signed_temp[4:2], 4),
        $past(r1_signed_temp[1:0], 4) & {2{$past(r1_filt_en, 4)}}, 3'h0}; endproperty
    a_pair: assert property (p_pair) else $error("low byte not the capture");
    property p_unmap; rd_stb && !(cmd_code inside {8'h10, 8'h11, 8'h12, 8'h19, 8'h1a, 8'h20, 8'h21,
        8'h22, 8'h29, 8'h2a}) |=> !rd_hit && rd_data == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read answered");
    property p_stand; !rd_stb |=> $stable(rd_data) && $stable(rd_hit); endproperty
    a_stand: assert property (p_stand) else $error("read byte moved");
    property p_loc_hi; rd_stb && cmd_code == 8'h10 |=> rd_data == $past(local_temp[10:3]) && rd_hit; endproperty
    a_loc_hi: assert property (p_loc_hi) else $error("local high byte");
    property p_loc_lo; rd_stb && cmd_code == 8'h20 |=> rd_data[4:0] == 5'h00; endproperty
    a_loc_lo: assert property (p_loc_lo) else $error("local low zeros");
    property p_rem_lo; rd_stb && cmd_code[7:4] == 4'h2 && cmd_code != 8'h20 |=> rd_data[2:0] == 3'h0; endproperty
    a_rem_lo: assert property (p_rem_lo) else $error("remote low zeros");
    property p_sgn_hi; s_hi |=> rd_data == $past(r1_signed_temp[12:5]); endproperty
    a_sgn_hi: assert property (p_sgn_hi) else $error("signed high byte");
    property p_uns_hi; rd_stb && cmd_code == 8'h19 |=> rd_data == $past(r1_unsigned_temp[12:5]); endproperty
    a_uns_hi: assert property (p_uns_hi) else $error("unsigned high byte");
    property p_sgn_lo; rd_stb && (cmd_code == 8'h21 || cmd_code == 8'h22) |=> rd_hit; endproperty
    a_sgn_lo: assert property (p_sgn_lo) else $error("signed low byte not answered");
endmodule // tvr_chk
bind tvr_readout tvr_chk u_tvr_chk (.clk_sys, .rst, .local_temp, .r1_signed_temp, .r2_signed_temp,
    .r1_unsigned_temp, .r2_unsigned_temp, .r1_filt_en, .r2_filt_en, .cmd_code, .rd_stb, .rd_data, .rd_hit);

// ---- tvr_host.sv ----
// tvr_host.sv: host side issuing command-byte reads
// assumes a one-cycle read strobe and a registered answer
`timescale 1ns/1ps
module tvr_host (
    input wire clk_sys,
    input wire [7:0] rd_data,
    input wire rd_hit,
    output logic [7:0] cmd_code = 8'h00,
    output logic rd_stb = 1'b0
);
    task automatic rd(input [7:0] c, output [7:0] d, output h);
        @(posedge clk_sys);
        cmd_code <= c;
        rd_stb <= 1'b1;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        cmd_code <= ~c;
        #1 d = rd_data;
        h = rd_hit;
    endtask
endmodule // tvr_host

// ---- temp_value_register_readout_tb_top.sv ----
// bench top: drives readings and reads registers through the host model
// assumes tvr_readout, tvr_host and the bound checker
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; $display("Error %s expected %h seen %h", n, e, g); end end
module temp_value_register_readout_tb_top;
    logic clk_sys = 1'b0, rst = 1'b1, r1_filt_en = 1'b1, r2_filt_en = 1'b0, rd_stb, rd_hit;
    logic [10:0] local_temp = 11'h000;
    logic [12:0] r1_signed_temp = 13'h0000, r2_signed_temp = 13'h0000;
    logic [12:0] r1_unsigned_temp = 13'h0000, r2_unsigned_temp = 13'h0000;
    logic [7:0] cmd_code, rd_data;
    int n_mismatch = 0, samples_checked = 0;
    tvr_readout u_tvr_readout (.clk_sys, .rst, .local_temp, .r1_signed_temp, .r2_signed_temp, .r1_unsigned_temp,
        .r2_unsigned_temp, .r1_filt_en, .r2_filt_en, .cmd_code, .rd_stb, .rd_data, .rd_hit);
    tvr_host u_tvr_host (.clk_sys, .rd_data, .rd_hit, .cmd_code, .rd_stb);
    always #2 clk_sys = ~clk_sys;
    task automatic rdc(input [7:0] c, input [7:0] e, input eh);
        logic [7:0] d;
        logic h;
        u_tvr_host.rd(c, d, h);
        `CHK("rd_data", e, d)
        `CHK("rd_hit", eh, h)
    endtask
    task automatic t_local;
        @(posedge clk_sys) local_temp <= 11'h4a5;
        rdc(8'h10, 8'h94, 1'b1);
        @(posedge clk_sys) local_temp <= 11'h123;
        rdc(8'h20, 8'ha0, 1'b1);
        rdc(8'h20, 8'h60, 1'b1);
    endtask
    task automatic t_remote;
        @(posedge clk_sys) r1_signed_temp <= 13'h1abc;
        rdc(8'h11, 8'hd5, 1'b1);
        @(posedge clk_sys) r1_signed_temp <= 13'h0f37;
        rdc(8'h11, 8'h79, 1'b1);
        @(posedge clk_sys) r1_signed_temp <= 13'h1fff;
        rdc(8'h21, 8'hb8, 1'b1);
        @(posedge clk_sys) r2_signed_temp <= 13'h1e1f;
        rdc(8'h12, 8'hf0, 1'b1);
        rdc(8'h22, 8'he0, 1'b1);
    endtask
    task automatic t_unsigned;
        @(posedge clk_sys) r1_unsigned_temp <= 13'h1f6a;
        rdc(8'h19, 8'hfb, 1'b1);
        @(posedge clk_sys) r1_unsigned_temp <= 13'h0000;
        r1_signed_temp <= 13'h0003;
        rdc(8'h21, 8'h18, 1'b1);
        rdc(8'h29, 8'h50, 1'b1);
        @(posedge clk_sys) r2_unsigned_temp <= 13'h1234;
        rdc(8'h1a, 8'h91, 1'b1);
        rdc(8'h2a, 8'ha0, 1'b1);
    endtask
    task automatic t_unmapped;
        rdc(8'h30, 8'h00, 1'b0);
    endtask
    task automatic t_filter;
        @(posedge clk_sys) r1_filt_en <= 1'b0;
        r2_filt_en <= 1'b1;
        r1_unsigned_temp <= 13'h001f;
        r2_signed_temp <= 13'h0003;
        rdc(8'h29, 8'he0, 1'b1);
        rdc(8'h22, 8'h18, 1'b1);
    endtask
    task automatic t_reset;
        rdc(8'h10, 8'h24, 1'b1);
        @(posedge clk_sys) rst <= 1'b1;
        local_temp <= 11'h7ff;
        repeat (2) @(posedge clk_sys);
        `CHK("rd_data", 8'h00, rd_data)
        `CHK("rd_hit", 1'b0, rd_hit)
        rst <= 1'b0;
        rdc(8'h20, 8'he0, 1'b1);
    endtask
    task automatic end_sim;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        t_local;
        t_remote;
        t_unsigned;
        t_filter;
        t_reset;
        t_unmapped;
        end_sim;
    end
    initial begin
        #100000;
        n_mismatch++;
        end_sim;
    end
endmodule // temp_value_register_readout_tb_top
